// >>> hdl/atc_defines.svh
/*
 * Constants of the address-translation cache block: register offsets,
 * field positions, reset values and fixed geometry.
 * Assumes inclusion by bare name from the design module.
 */
`ifndef ATC_DEFINES_SVH
`define ATC_DEFINES_SVH

// register byte offsets (low eight address bits decoded)
`define ATC_OFF_CTRL       8'h00
`define ATC_OFF_WIN0       8'h04
`define ATC_OFF_WIN1       8'h08
`define ATC_OFF_STAT       8'h0C

// control register fields
`define ATC_CTRL_EN        0
`define ATC_CTRL_P8K       1
`define ATC_CTRL_RST       32'h0000_0000

// window register fields
`define ATC_WIN_BASE_HI    31
`define ATC_WIN_BASE_LO    24
`define ATC_WIN_MASK_HI    23
`define ATC_WIN_MASK_LO    16
`define ATC_WIN_EN         15
`define ATC_WIN_PS_BOTH    14
`define ATC_WIN_PS_SUP     13
`define ATC_WIN_U_HI       9
`define ATC_WIN_U_LO       8
`define ATC_WIN_CM_HI      6
`define ATC_WIN_CM_LO      5
`define ATC_WIN_WP         2
`define ATC_WIN_RST        32'h0000_0000

// geometry
`define ATC_WAYS           4
`define ATC_SETS           16
`define ATC_ENTRIES        64

`endif

// >>> hdl/atc_pkg.sv
/*
 * Types of the address-translation cache block.
 * Assumes atc_defines.svh is on the include path.
 */
package atc_pkg;
	typedef enum logic {
		ATC_ST_IDLE,
		ATC_ST_WALK
	} atc_state_t;

	// cache mode: 00 wt cachable, 01 copyback, 10 noncachable serialized, 11 noncachable
	typedef logic [1:0] atc_cm_t;

	typedef struct packed {
		logic [19:0] pa;
		logic [1:0]  uattr;
		logic        sup_only;
		atc_cm_t     cm;
		logic        modified;
		logic        wprot;
		logic        resident;
		logic        walk_err;
		logic        global;
		logic        priv;
		logic [15:0] tag;
	} atc_entry_t;
endpackage : atc_pkg

// >>> hdl/atc_translate.sv
/*
 * One memory unit's translation path: two transparent windows, a 64-entry
 * four-way translation cache with flush, fill and modified-bit update, and
 * an AHB-Lite register slave. Assumes requester, flush source and table
 * walker run on mclk_in; the walker answers each search exactly once.
 */
// The AHB-Lite slave port and the register addresses are this design's own decisions.
// Operation
// - four-way, 64-entry cache of page translations
// - two-bit cache mode delivered with each access
// - privilege tag stored from access privilege
// - nonglobal-only flush spares global entries
// - tag compares all bits; 8K ignores lsb
// - write to unmodified entry triggers update search
// - resident bit only from clean search
// - supervisor-only pages refuse user accesses
// - user attribute bits echoed to outputs
// - valid set on load, cleared by flush
// - write-protected entry faults writes at once
// - set index from four bits above offset
// - tag and privilege match selects way
// - miss aborts, searches, fills, then retry
// - bit 12/16 handling differs per page size
// - fill invalid way else counter way; an update search refills the hit way
// - two windows, each individually enabled
// - window match on top byte under mask
// - window privilege select: user, super, both
// - window write protection aborts writes
// - window passes address; window zero wins
// - windows first, then cache, then search
// - hit on erroneous entry gives bus error
`timescale 1ns/100ps
`include "atc_defines.svh"

module atc_translate
	import atc_pkg::*;
#(
	parameter int WAYS = `ATC_WAYS,
	parameter int SETS = `ATC_SETS
) (
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic             hreadyout_out,
	output logic [31:0]      hrdata_out,
	output logic             hresp_out,
	input  wire logic        req_valid_in,
	input  wire logic [31:0] req_addr_in,
	input  wire logic        req_super_in,
	input  wire logic        req_write_in,
	output logic             req_ready_out,
	output logic             rsp_valid_out,
	output logic [31:0]      rsp_paddr_out,
	output logic [1:0]       rsp_cm_out,
	output logic             user_attr_out0,
	output logic             user_attr_out1,
	output logic             rsp_access_err_out,
	output logic             rsp_bus_err_out,
	output logic             rsp_retry_out,
	input  wire logic        selective_flush_request_in,
	input  wire logic        flush_all_request_in,
	input  wire logic        flush_nonglobal_in,
	input  wire logic [31:0] flush_addr_in,
	input  wire logic        flush_super_in,
	output logic             walk_req_out,
	output logic [31:12]     walk_addr_out,
	output logic             walk_super_out,
	output logic             walk_write_out,
	input  wire logic        walk_done_in,
	input  wire logic [19:0] walk_pa_in,
	input  wire logic [1:0]  walk_cm_in,
	input  wire logic [1:0]  walk_uattr_in,
	input  wire logic        walk_sup_only_in,
	input  wire logic        walk_wprot_in,
	input  wire logic        walk_modified_in,
	input  wire logic        walk_global_in,
	input  wire logic        walk_resident_in,
	input  wire logic        walk_err_in
);
	if (WAYS != 4 || SETS != 16) begin : g_geom_check
		$error("atc_translate serves only four ways of sixteen sets");
	end

	function automatic logic win_match(input logic [31:0] w, input logic [7:0] hi,
		input logic sup);
		logic [7:0] diff;
		diff = (w[`ATC_WIN_BASE_HI:`ATC_WIN_BASE_LO] ^ hi) &
			~w[`ATC_WIN_MASK_HI:`ATC_WIN_MASK_LO];
		win_match = w[`ATC_WIN_EN] && (w[`ATC_WIN_PS_BOTH] || w[`ATC_WIN_PS_SUP] == sup) &&
			(diff == 8'h00);
	endfunction : win_match

	function automatic logic [3:0] set_of(input logic [31:0] a, input logic p8k);
		set_of = p8k ? a[16:13] : a[15:12];
	endfunction : set_of

	atc_state_t  state_q;
	atc_entry_t  entry_q [WAYS][SETS];
	logic [63:0] valid_q;
	logic [31:0] ctrl_q;
	logic [31:0] win_q [2];
	logic [1:0]  repl_q;
	logic        upd_q;
	logic [1:0]  upd_way_q;
	logic [3:0]  walk_set_q;
	logic [15:0] walk_tag_q;
	logic        rd_pend_q;
	logic        wr_pend_q;
	logic [7:0]  bus_addr_q;

	logic        take;
	logic        p8k;
	logic [3:0]  lk_set;
	logic [3:0]  hit_vec;
	logic        hit;
	logic [1:0]  hit_way;
	atc_entry_t  he;
	logic        win0_hit;
	logic        win1_hit;
	logic        win_any;
	logic [31:0] win_sel;
	logic [3:0]  inv_vec;
	logic [1:0]  fill_way;
	logic        fill;

	assign take = req_valid_in && req_ready_out;
	assign p8k  = ctrl_q[`ATC_CTRL_P8K];
	assign fill = (state_q == ATC_ST_WALK) && walk_done_in;

	always_comb begin
		lk_set   = set_of(req_addr_in, p8k);
		win0_hit = win_match(win_q[0], req_addr_in[31:24], req_super_in);
		win1_hit = win_match(win_q[1], req_addr_in[31:24], req_super_in);
		win_any  = win0_hit || win1_hit;
		win_sel  = win0_hit ? win_q[0] : win_q[1];
		hit_way  = 2'h0;
		for (int w = 0; w < WAYS; w++) begin
			hit_vec[w] = valid_q[w*SETS + int'(lk_set)] &&
				entry_q[w][lk_set].priv == req_super_in &&
				entry_q[w][lk_set].tag[15:1] == req_addr_in[31:17] &&
				(p8k || entry_q[w][lk_set].tag[0] == req_addr_in[16]);
			inv_vec[w] = !valid_q[w*SETS + int'(walk_set_q)];
		end
		for (int w = WAYS - 1; w >= 0; w--) begin
			if (hit_vec[w]) begin
				hit_way = 2'(w);
			end
		end
		hit = |hit_vec;
		he  = entry_q[hit_way][lk_set];
		fill_way = repl_q;
		for (int w = WAYS - 1; w >= 0; w--) begin
			if (inv_vec[w]) begin
				fill_way = 2'(w);
			end
		end
		if (upd_q) begin
			fill_way = upd_way_q;
		end
	end

	// lookup and answer
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q            <= ATC_ST_IDLE;
			req_ready_out      <= 1'b1;
			rsp_valid_out      <= 1'b0;
			rsp_paddr_out      <= 32'h0000_0000;
			rsp_cm_out         <= 2'h0;
			user_attr_out0     <= 1'b0;
			user_attr_out1     <= 1'b0;
			rsp_access_err_out <= 1'b0;
			rsp_bus_err_out    <= 1'b0;
			rsp_retry_out      <= 1'b0;
			walk_req_out       <= 1'b0;
			walk_addr_out      <= 20'h0_0000;
			walk_super_out     <= 1'b0;
			walk_write_out     <= 1'b0;
			upd_q              <= 1'b0;
			upd_way_q          <= 2'h0;
			walk_set_q         <= 4'h0;
			walk_tag_q         <= 16'h0000;
		end else begin
			rsp_valid_out      <= take;
			rsp_access_err_out <= 1'b0;
			rsp_bus_err_out    <= 1'b0;
			rsp_retry_out      <= 1'b0;
			if (take) begin
				rsp_paddr_out  <= req_addr_in;
				rsp_cm_out     <= 2'h0;
				user_attr_out0 <= 1'b0;
				user_attr_out1 <= 1'b0;
				if (win_any) begin
					rsp_cm_out     <= win_sel[`ATC_WIN_CM_HI:`ATC_WIN_CM_LO];
					user_attr_out0 <= win_sel[`ATC_WIN_U_LO];
					user_attr_out1 <= win_sel[`ATC_WIN_U_HI];
					rsp_access_err_out <= req_write_in && win_sel[`ATC_WIN_WP];
				end else if (ctrl_q[`ATC_CTRL_EN] && hit) begin
					rsp_paddr_out  <= {he.pa[19:1], p8k ? req_addr_in[12] : he.pa[0],
						req_addr_in[11:0]};
					rsp_cm_out     <= he.cm;
					user_attr_out0 <= he.uattr[0];
					user_attr_out1 <= he.uattr[1];
					if (he.walk_err || !he.resident) begin
						rsp_bus_err_out <= 1'b1;
					end else if ((he.sup_only && !req_super_in) ||
						(req_write_in && he.wprot)) begin
						rsp_access_err_out <= 1'b1;
					end else if (req_write_in && !he.modified) begin
						rsp_retry_out <= 1'b1;
						upd_q         <= 1'b1;
						upd_way_q     <= hit_way;
					end
				end else if (ctrl_q[`ATC_CTRL_EN]) begin
					rsp_retry_out <= 1'b1;
					upd_q         <= 1'b0;
				end
				if (!win_any && ctrl_q[`ATC_CTRL_EN] && (!hit || (req_write_in &&
					!he.modified && !he.wprot && !he.walk_err && he.resident &&
					!(he.sup_only && !req_super_in)))) begin
					state_q        <= ATC_ST_WALK;
					req_ready_out  <= 1'b0;
					walk_req_out   <= 1'b1;
					walk_addr_out  <= req_addr_in[31:12];
					walk_super_out <= req_super_in;
					walk_write_out <= req_write_in;
					walk_set_q     <= lk_set;
					walk_tag_q     <= req_addr_in[31:16];
				end
			end
			if (fill) begin
				state_q       <= ATC_ST_IDLE;
				req_ready_out <= 1'b1;
				walk_req_out  <= 1'b0;
				upd_q         <= 1'b0;
			end
		end
	end

	// replacement counter steps on every lookup
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			repl_q <= 2'h0;
		end else if (take) begin
			repl_q <= repl_q + 2'h1;
		end
	end

	// entry store: flush first, a fill in the same cycle overrides its own slot
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			valid_q <= 64'h0000_0000_0000_0000;
		end else begin
			for (int w = 0; w < WAYS; w++) begin
				for (int s = 0; s < SETS; s++) begin
					if ((flush_all_request_in || (selective_flush_request_in &&
						4'(s) == set_of(flush_addr_in, p8k) &&
						entry_q[w][s].priv == flush_super_in &&
						entry_q[w][s].tag[15:1] == flush_addr_in[31:17] &&
						(p8k || entry_q[w][s].tag[0] == flush_addr_in[16]))) &&
						!(flush_nonglobal_in && entry_q[w][s].global)) begin
						valid_q[w*SETS + s] <= 1'b0;
					end
				end
			end
			if (fill) begin
				valid_q[int'(fill_way)*SETS + int'(walk_set_q)] <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (fill) begin
			entry_q[fill_way][walk_set_q] <= '{
				pa:       walk_pa_in,
				uattr:    walk_uattr_in,
				sup_only: walk_sup_only_in,
				cm:       walk_cm_in,
				modified: walk_modified_in,
				wprot:    walk_wprot_in,
				resident: walk_resident_in && !walk_err_in,
				walk_err: walk_err_in,
				global:   walk_global_in,
				priv:     walk_super_out,
				tag:      walk_tag_q};
		end
	end

	// bus slave: writes land in the data phase, reads take one wait state
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			hreadyout_out <= 1'b1;
			hresp_out     <= 1'b0;
			hrdata_out    <= 32'h0000_0000;
			rd_pend_q     <= 1'b0;
			wr_pend_q     <= 1'b0;
			bus_addr_q    <= 8'h00;
			ctrl_q        <= `ATC_CTRL_RST;
			win_q[0]      <= `ATC_WIN_RST;
			win_q[1]      <= `ATC_WIN_RST;
		end else begin
			rd_pend_q <= 1'b0;
			wr_pend_q <= 1'b0;
			if (hsel_in && htrans_in[1] && hready_in) begin
				bus_addr_q    <= haddr_in[7:0];
				rd_pend_q     <= !hwrite_in;
				wr_pend_q     <= hwrite_in;
				hreadyout_out <= hwrite_in;
			end
			if (wr_pend_q) begin
				case (bus_addr_q)
					`ATC_OFF_CTRL: ctrl_q   <= hwdata_in & 32'h0000_0003;
					`ATC_OFF_WIN0: win_q[0] <= hwdata_in & 32'hFFFF_E364;
					`ATC_OFF_WIN1: win_q[1] <= hwdata_in & 32'hFFFF_E364;
					default: ;
				endcase
			end
			if (rd_pend_q) begin
				hreadyout_out <= 1'b1;
				case (bus_addr_q)
					`ATC_OFF_CTRL: hrdata_out <= ctrl_q;
					`ATC_OFF_WIN0: hrdata_out <= win_q[0];
					`ATC_OFF_WIN1: hrdata_out <= win_q[1];
					`ATC_OFF_STAT: hrdata_out <= {28'h000_0000, repl_q, upd_q,
						state_q == ATC_ST_WALK};
					default:       hrdata_out <= 32'h0000_0000;
				endcase
			end
		end
	end

	chk_walk_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
		walk_req_out && !walk_done_in |=> walk_req_out && !req_ready_out)
		else $error("search request dropped before answer");
	chk_miss_search: assert property (@(posedge mclk_in) disable iff (rst_in)
		take && !win_any && ctrl_q[0] && !hit |=> rsp_retry_out && walk_req_out)
		else $error("miss did not abort and search");
	chk_win_pass: assert property (@(posedge mclk_in) disable iff (rst_in)
		take && win_any |=> rsp_paddr_out == $past(req_addr_in) && !walk_req_out)
		else $error("window access not passed through");
	chk_win_wprot: assert property (@(posedge mclk_in) disable iff (rst_in)
		take && win0_hit && win_q[0][2] && req_write_in |=> rsp_access_err_out)
		else $error("protected window write not aborted");
	chk_flush_all: assert property (@(posedge mclk_in) disable iff (rst_in)
		flush_all_request_in && !flush_nonglobal_in && !fill |=> valid_q == 64'h0)
		else $error("flush all left valid entries");
	chk_sup_only: assert property (@(posedge mclk_in) disable iff (rst_in)
		take && !win_any && ctrl_q[0] && hit && he.resident && !he.walk_err &&
		he.sup_only && !req_super_in |=> rsp_access_err_out)
		else $error("user access to supervisor page allowed");
	chk_repl_step: assert property (@(posedge mclk_in) disable iff (rst_in)
		take |=> repl_q == $past(repl_q) + 2'h1)
		else $error("replacement counter did not step");
	chk_bus_error: assert property (@(posedge mclk_in) disable iff (rst_in)
		take && !win_any && ctrl_q[0] && hit && he.walk_err |=> rsp_bus_err_out)
		else $error("erroneous entry hit without bus error");
	chk_fill_ready: assert property (@(posedge mclk_in) disable iff (rst_in)
		fill |=> req_ready_out && !walk_req_out && !rsp_valid_out)
		else $error("fill did not release requester");
	chk_fill_resident: assert property (@(posedge mclk_in) disable iff (rst_in)
		fill && walk_err_in |=> !entry_q[$past(fill_way)][$past(walk_set_q)].resident)
		else $error("failed search left a resident entry");
	cov_win_hit: cover property (@(posedge mclk_in) take && win_any);
	cov_miss_fill: cover property (@(posedge mclk_in) take && !hit ##[1:50] fill);
	cov_mod_update: cover property (@(posedge mclk_in) rsp_retry_out && upd_q);
	cov_flush_sel: cover property (@(posedge mclk_in) selective_flush_request_in);
endmodule : atc_translate

// >>> verification/atc_walk_model.sv
/* table-walk partner: answers each search once, after lat_in cycles.
   assumes the bench holds the descriptor steady on desc_in during a walk. */
`timescale 1ns/100ps
module atc_walk_model (
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	input  wire logic        walk_req_in,
	input  wire logic [29:0] desc_in,
	input  wire logic [3:0]  lat_in,
	output logic             done_out,
	output logic [29:0]      fld_out
);
	logic [3:0] cnt_q;
	logic       ans_q;

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q    <= 4'h0;
			ans_q    <= 1'b0;
			done_out <= 1'b0;
			fld_out  <= 30'h0;
		end else begin
			done_out <= 1'b0;
			// fields toggle outside the answer cycle so stale data never holds steady
			fld_out  <= ~fld_out;
			cnt_q    <= walk_req_in ? cnt_q + 4'h1 : 4'h0;
			if (!walk_req_in) begin
				ans_q <= 1'b0;
			end else if (!ans_q && cnt_q >= lat_in) begin
				ans_q    <= 1'b1;
				done_out <= 1'b1;
				fld_out  <= desc_in;
			end
		end
	end
endmodule : atc_walk_model

// >>> verification/address_translation_cache_ttw_tb_top.sv
/* self-checking bench for atc_translate against an associative-array model.
   assumes the design, its package and atc_walk_model are compiled first. */
`timescale 1ns/100ps
module address_translation_cache_ttw_tb_top;
	logic        mclk_in = 0;
	logic        rst_in = 1;
	logic        hsel = 0, hwrite = 0, hrdy, hresp;
	logic [1:0]  htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, ra = 0, pa, fad = 0;
	logic        rv = 0, rs = 0, rw = 0, rrdy, vld, ua0, ua1, aerr, berr, rty;
	logic        fs = 0, fa = 0, fn = 0, fsu = 0, wreq, wdone;
	logic [1:0]  cm;
	logic [29:0] desc = 0, fld;
	logic [3:0]  lat = 0;
	logic [19:0] wad;
	logic        wsu, wwr;
	logic [31:0] wcf [3] = '{32'h400F_C144, 32'h400F_8144, 32'h400F_4144};
	logic [7:0]  hib [3] = '{8'h40, 8'h4A, 8'h50};
	int          nt = 0, v;
	logic [31:0] rs_q = 32'h58, e_pa;
	logic [1:0]  e_cm, e_ua;
	int          n_fail = 0, compares = 0, cyc = 0, ctl = 0, w0 = 0, w1 = 0, key;
	int          mc[int];

	always #4 mclk_in = ~mclk_in;

	atc_translate DUT (.mclk_in(mclk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hrdy), .hreadyout_out(hrdy), .hrdata_out(hrdata), .hresp_out(hresp),
		.req_valid_in(rv), .req_addr_in(ra), .req_super_in(rs), .req_write_in(rw),
		.req_ready_out(rrdy), .rsp_valid_out(vld), .rsp_paddr_out(pa), .rsp_cm_out(cm),
		.user_attr_out0(ua0), .user_attr_out1(ua1), .rsp_access_err_out(aerr),
		.rsp_bus_err_out(berr), .rsp_retry_out(rty), .selective_flush_request_in(fs),
		.flush_all_request_in(fa), .flush_nonglobal_in(fn), .flush_addr_in(fad),
		.flush_super_in(fsu), .walk_req_out(wreq), .walk_addr_out(wad), .walk_super_out(wsu),
		.walk_write_out(wwr), .walk_done_in(wdone), .walk_pa_in(fld[19:0]),
		.walk_cm_in(fld[21:20]), .walk_uattr_in(fld[23:22]), .walk_sup_only_in(fld[24]),
		.walk_wprot_in(fld[25]), .walk_modified_in(fld[26]), .walk_global_in(fld[27]),
		.walk_resident_in(fld[28]), .walk_err_in(fld[29]));

	atc_walk_model walker (.mclk_in(mclk_in), .rst_in(rst_in), .walk_req_in(wreq),
		.desc_in(desc), .lat_in(lat), .done_out(wdone), .fld_out(fld));

	function automatic logic [31:0] rng();
		rs_q ^= rs_q << 13;
		rs_q ^= rs_q >> 17;
		rs_q ^= rs_q << 5;
		return rs_q;
	endfunction : rng

	function automatic bit wm(input int r, input logic [31:0] a, input logic s);
		return r[15] && (((a[31:24] ^ r[31:24]) & ~r[23:16]) == 0) && (r[14] || r[13] == s);
	endfunction : wm

	// kinds: 0 ok, 1 access error, 2 bus error, 3 retry with search
	function automatic int mdl(input logic [31:0] a, input logic s, w);
		int r, d;
		r = wm(w0, a, s) ? w0 : w1;
		key = {s, ctl[1], a[31:13], a[12] & ~ctl[1]};
		e_pa = a;
		e_cm = r[6:5];
		e_ua = r[9:8];
		if (wm(w0, a, s) || wm(w1, a, s)) return int'(w && r[2]);
		e_cm = 0;
		e_ua = 0;
		if (!ctl[0]) return 0;
		if (!mc.exists(key)) return 3;
		d = mc[key];
		if (d[29] || !d[28]) return 2;
		if ((d[24] && !s) || (w && d[25])) return 1;
		if (w && !d[26]) return 3;
		e_pa = ctl[1] ? {d[19:1], a[12:0]} : {d[19:0], a[11:0]};
		e_cm = d[21:20];
		e_ua = d[23:22];
		return 0;
	endfunction : mdl

	task automatic chk(input logic [39:0] got, exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict

	task automatic bx(input logic wr, input logic [7:0] a, input logic [31:0] d);
		logic [31:0] e;
		@(posedge mclk_in);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge mclk_in); while (hrdy !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk_in); while (hrdy !== 1'b1);
		chk(hresp, 0);
		e = a == 0 ? ctl : a == 4 ? w0 : a == 8 ? w1 : a == 12 ? nt % 4 * 4 : 0;
		if (!wr) chk(hrdata, e);
		if (wr && a == 8'h00) ctl = d & 3;
		if (wr && a == 8'h04) w0 = d & 32'hFFFF_E364;
		if (wr && a == 8'h08) w1 = d & 32'hFFFF_E364;
	endtask : bx

	task automatic xl(input logic [31:0] a, input logic s, w);
		int k;
		k = mdl(a, s, w);
		nt++;
		@(posedge mclk_in);
		rv <= 1;
		ra <= a;
		rs <= s;
		rw <= w;
		lat <= 4'(rng());
		do @(posedge mclk_in); while (rrdy !== 1'b1);
		rv <= 0;
		@(posedge mclk_in);
		chk({vld, aerr, berr, rty, wreq, rrdy},
			{1'b1, k == 1, k == 2, k == 3, k == 3, k != 3});
		if (k == 0) chk({pa, cm, ua1, ua0}, {e_pa, e_cm, e_ua});
		if (k == 3) chk({wad, wsu, wwr}, {a[31:12], s, w});
		if (k == 3) mc[key] = desc;
		if (k == 3) do @(posedge mclk_in); while (rrdy !== 1'b1);
	endtask : xl

	task automatic fl(input logic all, ng, input logic [31:0] a, input logic s);
		int q[$];
		@(posedge mclk_in);
		fa <= all;
		fs <= !all;
		fn <= ng;
		fad <= a;
		fsu <= s;
		@(posedge mclk_in);
		fa <= 0;
		fs <= 0;
		void'(mdl(a, s, 0));
		foreach (mc[i]) if ((all || i == key) && !(ng && mc[i][27])) q.push_back(i);
		foreach (q[j]) mc.delete(q[j]);
	endtask : fl

	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			give_verdict();
		end
	end

	initial begin
		logic [31:0] r, a;
		logic [31:0] fa4 [4];
		logic        s;
		repeat (2) @(posedge mclk_in);
		rst_in <= 0;
		@(posedge mclk_in);
		chk({hrdy, rrdy, vld, wreq}, 4'hC);
		for (int i = 0; i < 5; i++) bx(0, 8'(i * 4), 0);
		bx(1, 8'h10, 32'hFFFF_FFFF);
		bx(0, 8'h10, 0);
		bx(1, 8'h04, 32'hFFFF_FFFF);
		bx(0, 8'h04, 0);
		$display("test regs done");
		for (int c = 0; c < 3; c++) begin
			bx(1, 8'h04, wcf[c]);
			bx(1, 8'h08, 32'h4000_A260);
			for (int j = 0; j < 12; j++) begin
				r = rng();
				xl({hib[j / 4], r[23:0]}, j[0], j[1]);
			end
		end
		$display("test windows done");
		bx(1, 8'h04, 0);
		bx(1, 8'h08, 0);
		fl(1, 0, 0, 0);
		bx(1, 8'h00, 32'h1);
		for (int i = 0; i < 9; i++) begin
			r = rng();
			a = {r[31:16], 4'(i), r[11:0]};
			r = rng();
			desc <= {i == 7, i != 8, 1'b0, i != 6, i == 5, i == 4, 2'(i), 2'(i), r[19:0]};
			s = (i != 4);
			xl(a, s, 0);
			xl(a, s, 0);
			desc[26] <= 1'b1;
			xl(a, s, 1);
			xl(a, s, 1);
			xl(a, !s, 0);
		end
		desc <= {10'h100, r[19:0]};
		for (int i = 0; i < 8; i++) begin
			r = rng();
			if (i < 4) fa4[i] = {r[31:16], 4'hF, r[11:0]};
			xl(fa4[i % 4], 1, 0);
		end
		fl(0, 0, fa4[3], 1);
		xl(fa4[3], 1, 0);
		r = rng();
		xl({r[31:16], 4'hF, r[11:0]}, 1, 0);
		// full set: the counter value at the fill names the evicted way
		v = nt % 4;
		void'(mdl(fa4[v], 1, 0));
		mc.delete(key);
		for (int i = 1; i < 5; i++) xl(fa4[(v + i) % 4], 1, 0);
		desc[27] <= 1'b1;
		xl({r[31:16], 16'h9000}, 1, 0);
		desc[27] <= 1'b0;
		xl({r[31:16], 16'hA000}, 1, 0);
		fl(1, 1, 0, 0);
		xl({r[31:16], 16'h9000}, 1, 0);
		xl({r[31:16], 16'hA000}, 1, 0);
		bx(0, 8'h0C, 0);
		$display("test cache done");
		bx(1, 8'h00, 0);
		fl(1, 0, 0, 0);
		bx(1, 8'h00, 32'h3);
		for (int i = 0; i < 4; i++) begin
			r = rng();
			a = {r[31:13], 1'b0, r[11:0]};
			xl(a, 1, 0);
			xl(a | 32'h1000, 1, 0);
			xl(a ^ 32'h0001_0000, 1, 0);
		end
		$display("test pages done");
		give_verdict();
	end
endmodule : address_translation_cache_ttw_tb_top
